//--- design/phy_port_diag_irq_regs.sv
// Per-port auxiliary register bank: cable diagnostic, link state, symbol error count, events, crossover.
// Assumes a simple same-clock register port and one-cycle event pulses from the transceiver core.
`timescale 1ns/100ps
module phy_port_diag_irq_regs import pdi_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Register port
   input wire pdi_reg_req_s regReq,
   output logic [DATA_W-1:0] regRdata,
   output logic regRvalid,
   // Transceiver status
   input wire logic gigLinkUp,
   input wire logic fastLinkUp,
   input wire pdi_phy_event_s phyEvents,
   input wire logic rxSymbolErrorFrame,
   // Cable diagnostic engine
   output logic diagStart,
   output logic diagAbort,
   output logic [1:0] diagPair,
   input wire logic diagDone,
   input wire logic [1:0] diagResult,
   // Crossover control
   output logic autoCrossoverEn,
   output logic forcedStraightSelect,
   output logic forcedCrossedSelect,
   // Interrupt request
   output logic irq
);
   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic rvalid;
      logic [EVT_W-1:0] evtEnable;
      logic [EVT_W-1:0] evtFlag;
      logic [DATA_W-1:0] symErrCount;
      logic [DATA_W-1:0] xovr;
      logic [1:0] pair;
      logic [2:0] diagRsvd;
      logic [1:0] linkState;
      logic autoXovr;
      logic forceStraight;
      logic forceCrossed;
      logic irq;
   } pdi_state_s;

   pdi_state_s st, next_st;
   logic diagBusy;
   logic [1:0] diagOutcome;
   logic wrDiag;
   logic diagStartReq;
   logic diagStopReq;
   logic [EVT_W-1:0] evtNow;
   logic linkNow;
   logic linkWas;

   function automatic logic hit(input pdi_reg_req_s req, input logic [ADDR_W-1:0] ofs, input logic isWr);
      hit = (isWr ? req.wr : req.rd) && (req.addr == ofs);
   endfunction : hit

   assign wrDiag = hit(regReq, OFS_CABLE_DIAG, 1'b1);
   assign diagStartReq = wrDiag && regReq.wdata[DIAG_START_BIT];
   assign diagStopReq = wrDiag && !regReq.wdata[DIAG_START_BIT];

   pdi_cable_diag u_diag (
      .clk(clk),
      .rstn(rstn),
      .startReq(diagStartReq),
      .stopReq(diagStopReq),
      .pairSel(regReq.wdata[DIAG_PAIR_LSB +: 2]),
      .engineDone(diagDone),
      .engineResult(diagResult),
      .busy(diagBusy),
      .result(diagOutcome),
      .engineStart(diagStart),
      .engineAbort(diagAbort),
      .enginePair(diagPair)
   );

   // Link edges come from the registered state so both flags see the same history
   assign linkNow = gigLinkUp || fastLinkUp;
   assign linkWas = |st.linkState;
   always_comb begin
      evtNow = '0;
      evtNow[EVT_JABBER] = phyEvents.jabber;
      evtNow[EVT_RX_ERROR] = phyEvents.rxError;
      evtNow[EVT_PAGE_RX] = phyEvents.pageRx;
      evtNow[EVT_PARALLEL_FAULT] = phyEvents.parallelFault;
      evtNow[EVT_PARTNER_ACK] = phyEvents.partnerAck;
      evtNow[EVT_LINK_DOWN] = linkWas && !linkNow;
      evtNow[EVT_REMOTE_FAULT] = phyEvents.remoteFault;
      evtNow[EVT_LINK_UP] = !linkWas && linkNow;
   end

   always_comb begin
      next_st = st;
      next_st.rvalid = 1'b0;
      next_st.linkState[LINK_GIG_BIT] = gigLinkUp;
      next_st.linkState[LINK_FAST_BIT] = fastLinkUp;

      // Writes
      if (wrDiag) begin
         next_st.pair = regReq.wdata[DIAG_PAIR_LSB +: 2];
         next_st.diagRsvd = {regReq.wdata[DIAG_RSVD_HI_BIT], regReq.wdata[DIAG_RSVD_LO_LSB +: 2]};
      end else if (hit(regReq, OFS_EVENT, 1'b1)) begin
         next_st.evtEnable = regReq.wdata[EVT_ENABLE_LSB +: EVT_W];
      end else if (hit(regReq, OFS_CROSSOVER, 1'b1)) begin
         next_st.xovr = regReq.wdata;
      end

      // Reads, with clear-on-read side effects
      if (regReq.rd) begin
         next_st.rvalid = 1'b1;
         if (hit(regReq, OFS_CABLE_DIAG, 1'b0)) begin
            next_st.rdata = {diagBusy, st.diagRsvd[2], st.pair, st.diagRsvd[1:0], diagOutcome, 8'h00};
         end else if (hit(regReq, OFS_LINK_STATE, 1'b0)) begin
            next_st.rdata = {14'h0000, st.linkState};
         end else if (hit(regReq, OFS_RX_SYMBOL_ERROR, 1'b0)) begin
            next_st.rdata = st.symErrCount;
            next_st.symErrCount = RST_COUNT;
         end else if (hit(regReq, OFS_EVENT, 1'b0)) begin
            next_st.rdata = {st.evtEnable, st.evtFlag};
            next_st.evtFlag = RST_EVT;
         end else if (hit(regReq, OFS_CROSSOVER, 1'b0)) begin
            next_st.rdata = st.xovr;
         end else begin
            next_st.rdata = '0;
         end
      end

      // A new event or count in the clearing cycle is kept: set wins over clear
      next_st.evtFlag = next_st.evtFlag | evtNow;
      if (rxSymbolErrorFrame && (next_st.symErrCount != 16'hFFFF)) begin
         // Saturates rather than wrapping so a full counter is not mistaken for a quiet line
         next_st.symErrCount = next_st.symErrCount + 16'h0001;
      end

      next_st.autoXovr = !next_st.xovr[XOVR_OVERRIDE_BIT];
      next_st.forceStraight = next_st.xovr[XOVR_OVERRIDE_BIT] && next_st.xovr[XOVR_STRAIGHT_BIT];
      next_st.forceCrossed = next_st.xovr[XOVR_OVERRIDE_BIT] && !next_st.xovr[XOVR_STRAIGHT_BIT];
      next_st.irq = |(next_st.evtFlag & next_st.evtEnable);
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st <= '{rdata: '0, rvalid: 1'b0, evtEnable: RST_EVT, evtFlag: RST_EVT, symErrCount: RST_COUNT,
                 xovr: RST_XOVR, pair: RST_PAIR, diagRsvd: RST_DIAG_RSVD, linkState: 2'h0,
                 autoXovr: 1'b1, forceStraight: 1'b0, forceCrossed: 1'b0, irq: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign regRdata = st.rdata;
   assign regRvalid = st.rvalid;
   assign autoCrossoverEn = st.autoXovr;
   assign forcedStraightSelect = st.forceStraight;
   assign forcedCrossedSelect = st.forceCrossed;
   assign irq = st.irq;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // Read strobes that several checks below start from
   sequence sEventRead;
      hit(regReq, OFS_EVENT, 1'b0);
   endsequence
   sequence sCountRead;
      hit(regReq, OFS_RX_SYMBOL_ERROR, 1'b0);
   endsequence

   a_count_read_clear: assert property (sCountRead ##0 !rxSymbolErrorFrame |=> st.symErrCount == 16'h0000)
      else $error("Symbol error counter not cleared by read");
   a_count_set_wins: assert property (sCountRead ##0 rxSymbolErrorFrame |=> st.symErrCount == 16'h0001)
      else $error("Error frame lost in the clearing read");
   a_count_increment: assert property (
      !regReq.rd && rxSymbolErrorFrame && (st.symErrCount != 16'hFFFF)
      |=> st.symErrCount == $past(st.symErrCount) + 16'h0001)
      else $error("Symbol error counter did not count");
   a_flag_read_clear: assert property (
      sEventRead ##0 (evtNow == 8'h00)
      |=> regRvalid && (st.evtFlag == 8'h00) && (regRdata[7:0] == $past(st.evtFlag)))
      else $error("Event flags not returned and cleared by read");
   a_flag_set_wins: assert property (sEventRead |=> st.evtFlag == $past(evtNow))
      else $error("Event in the clearing read was lost");
   a_flag_stays: assert property (
      !hit(regReq, OFS_EVENT, 1'b0) |=> (st.evtFlag & $past(st.evtFlag)) == $past(st.evtFlag))
      else $error("Event flag dropped without a read");
   a_link_up_flag: assert property ($rose(linkNow) && (st.linkState == 2'h0) |=> st.evtFlag[EVT_LINK_UP])
      else $error("Link up flag not set");
   a_link_down_flag: assert property (linkWas && !linkNow |=> st.evtFlag[EVT_LINK_DOWN] && (st.linkState == 2'h0))
      else $error("Link down flag not set");
   a_link_readback: assert property (
      hit(regReq, OFS_LINK_STATE, 1'b0) |=> regRdata == {14'h0000, $past(gigLinkUp, 2), $past(fastLinkUp, 2)})
      else $error("Link state read does not show the link inputs");
   a_enable_write: assert property (hit(regReq, OFS_EVENT, 1'b1) |=> st.evtEnable == $past(regReq.wdata[15:8]))
      else $error("Event enables not written");
   a_irq_follow: assert property (irq == |(st.evtFlag & st.evtEnable))
      else $error("Interrupt request does not match enabled flags");
   a_irq_drop: assert property (sEventRead ##0 (evtNow == 8'h00) |=> !irq)
      else $error("Interrupt request stayed after a clearing read");
   a_crossover_force: assert property (hit(regReq, OFS_CROSSOVER, 1'b1) |=>
      (autoCrossoverEn == !$past(regReq.wdata[6]))
      && (forcedStraightSelect == ($past(regReq.wdata[6]) && $past(regReq.wdata[7]))))
      else $error("Crossover controls do not follow the written value");
   a_crossed_mode: assert property (
      forcedCrossedSelect |-> !autoCrossoverEn && !forcedStraightSelect && !st.xovr[XOVR_STRAIGHT_BIT])
      else $error("Crossed mode forced without override");
   a_straight_mode: assert property (
      forcedStraightSelect |-> !autoCrossoverEn && !forcedCrossedSelect && st.xovr[XOVR_STRAIGHT_BIT])
      else $error("Straight mode forced without override");
   a_auto_mode: assert property (
      autoCrossoverEn |-> !forcedStraightSelect && !forcedCrossedSelect && !st.xovr[XOVR_OVERRIDE_BIT])
      else $error("Automatic crossover active with override set");
   a_busy_readback: assert property (hit(regReq, OFS_CABLE_DIAG, 1'b0) |=> regRdata[15] == $past(diagBusy))
      else $error("Diagnostic busy bit not reflected on read");
   a_result_readback: assert property (
      hit(regReq, OFS_CABLE_DIAG, 1'b0) |=> (regRdata[9:8] == $past(diagOutcome)) && (regRdata[7:0] == 8'h00))
      else $error("Diagnostic result not reflected on read");
   a_pair_readback: assert property (hit(regReq, OFS_CABLE_DIAG, 1'b0) |=> regRdata[13:12] == $past(st.pair))
      else $error("Pair select not reflected on read");
   a_pair_write: assert property (wrDiag |=> st.pair == $past(regReq.wdata[13:12]))
      else $error("Pair select not written");
endmodule : phy_port_diag_irq_regs

//--- design/pdi_pkg.sv
// Constants and carrier types for the per-port diagnostic, link state and event register bank.
// Assumes one instance per copper port, all on the device core clock.
package pdi_pkg;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 12;
   localparam int EVT_W = 8;

   // Register offsets within one port's space
   localparam logic [ADDR_W-1:0] OFS_CABLE_DIAG = 12'h124;
   localparam logic [ADDR_W-1:0] OFS_LINK_STATE = 12'h126;
   localparam logic [ADDR_W-1:0] OFS_RX_SYMBOL_ERROR = 12'h12A;
   localparam logic [ADDR_W-1:0] OFS_EVENT = 12'h136;
   localparam logic [ADDR_W-1:0] OFS_CROSSOVER = 12'h138;

   // Field positions
   localparam int DIAG_START_BIT = 15;
   localparam int DIAG_RSVD_HI_BIT = 14;
   localparam int DIAG_PAIR_LSB = 12;
   localparam int DIAG_RSVD_LO_LSB = 10;
   localparam int DIAG_RESULT_LSB = 8;
   localparam int LINK_GIG_BIT = 1;
   localparam int LINK_FAST_BIT = 0;
   localparam int EVT_ENABLE_LSB = 8;
   localparam int EVT_JABBER = 7;
   localparam int EVT_RX_ERROR = 6;
   localparam int EVT_PAGE_RX = 5;
   localparam int EVT_PARALLEL_FAULT = 4;
   localparam int EVT_PARTNER_ACK = 3;
   localparam int EVT_LINK_DOWN = 2;
   localparam int EVT_REMOTE_FAULT = 1;
   localparam int EVT_LINK_UP = 0;
   localparam int XOVR_STRAIGHT_BIT = 7;
   localparam int XOVR_OVERRIDE_BIT = 6;

   // Values after reset
   localparam logic [1:0] RST_PAIR = 2'h0;
   localparam logic [1:0] RST_RESULT = 2'h0;
   localparam logic [DATA_W-1:0] RST_COUNT = 16'h0000;
   localparam logic [EVT_W-1:0] RST_EVT = 8'h00;
   localparam logic [DATA_W-1:0] RST_XOVR = 16'h0000;
   localparam logic [2:0] RST_DIAG_RSVD = 3'h0;

   // Diagnostic outcome codes
   localparam logic [1:0] DIAG_NO_FAULT = 2'h0;
   localparam logic [1:0] DIAG_OPEN = 2'h1;
   localparam logic [1:0] DIAG_SHORT = 2'h2;
   localparam logic [1:0] DIAG_RESERVED = 2'h3;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } pdi_reg_req_s;

   // One-cycle event pulses from the transceiver core
   typedef struct packed {
      logic jabber;
      logic rxError;
      logic pageRx;
      logic parallelFault;
      logic partnerAck;
      logic remoteFault;
   } pdi_phy_event_s;

   typedef enum logic {DIAG_IDLE, DIAG_RUN} pdi_diag_e;
endpackage : pdi_pkg

//--- design/pdi_cable_diag.sv
// Cable diagnostic sequencer: launches, tracks and aborts one test on the analog engine.
// Assumes the engine answers a start with exactly one done pulse unless it is aborted first.
`timescale 1ns/100ps
module pdi_cable_diag import pdi_pkg::*; (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Requests from the register bank
   input wire logic startReq,
   input wire logic stopReq,
   input wire logic [1:0] pairSel,
   // Analog engine answers
   input wire logic engineDone,
   input wire logic [1:0] engineResult,
   // Status and engine controls
   output logic busy,
   output logic [1:0] result,
   output logic engineStart,
   output logic engineAbort,
   output logic [1:0] enginePair
);
   typedef struct packed {
      pdi_diag_e state;
      logic [1:0] result;
      logic start;
      logic abort;
      logic [1:0] pair;
   } pdi_diag_state_s;

   pdi_diag_state_s st, next_st;

   always_comb begin
      next_st = st;
      next_st.start = 1'b0;
      next_st.abort = 1'b0;
      case (st.state)
         DIAG_IDLE: begin
            if (startReq) begin
               next_st.state = DIAG_RUN;
               next_st.start = 1'b1;
               next_st.pair = pairSel;
            end
         end
         DIAG_RUN: begin
            if (stopReq) begin
               // Abort leaves the previous outcome in place
               next_st.state = DIAG_IDLE;
               next_st.abort = 1'b1;
            end else if (engineDone) begin
               next_st.state = DIAG_IDLE;
               // The reserved code is never reported; treat it as no fault
               next_st.result = (engineResult == DIAG_RESERVED) ? DIAG_NO_FAULT : engineResult;
            end
         end
         default: next_st.state = DIAG_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st <= '{state: DIAG_IDLE, result: RST_RESULT, start: 1'b0, abort: 1'b0, pair: RST_PAIR};
      end else begin
         st <= next_st;
      end
   end

   assign busy = (st.state == DIAG_RUN);
   assign result = st.result;
   assign engineStart = st.start;
   assign engineAbort = st.abort;
   assign enginePair = st.pair;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence sLaunch;
      startReq && !busy;
   endsequence
   sequence sRunning;
      busy && engineStart && (enginePair == $past(pairSel));
   endsequence

   a_start_launches: assert property (sLaunch |=> sRunning)
      else $error("Start request did not launch a test");
   a_done_finishes: assert property (busy && engineDone && !stopReq |=> !busy && (result != DIAG_RESERVED))
      else $error("Test completion did not clear busy");
   a_stop_aborts: assert property (busy && stopReq |=> !busy && engineAbort && $stable(result))
      else $error("Stop request did not abort the test");
   a_result_held: assert property (!busy ##1 !busy |-> $stable(result))
      else $error("Result changed while no test ran");
endmodule : pdi_cable_diag

//--- tb/phy_port_diag_irq_regs_tb.sv
// Self-checking bench for the per-port diagnostic, link state, counter, event and crossover bank.
// Assumes the bank's own assertions sit in the design files; this bench drives every input itself.
`timescale 1ns/100ps
module phy_port_diag_irq_regs_tb;
   import pdi_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   pdi_reg_req_s regReq = '0;
   logic [DATA_W-1:0] regRdata;
   logic regRvalid;
   logic gigLinkUp = 1'b0;
   logic fastLinkUp = 1'b0;
   pdi_phy_event_s phyEvents = '0;
   logic rxSymbolErrorFrame = 1'b0;
   logic diagStart, diagAbort, diagDone = 1'b0;
   logic [1:0] diagPair, diagResult = 2'h0;
   logic autoCrossoverEn, forcedStraightSelect, forcedCrossedSelect, irq;
   int miscompares = 0;
   int testsRun = 0;
   logic [1:0] prevRes;
   int flagBit [6] = '{7, 6, 5, 4, 3, 1};

   always #4 clk = ~clk;

   phy_port_diag_irq_regs i_dut (.clk(clk), .rstn(rstn), .regReq(regReq), .regRdata(regRdata),
      .regRvalid(regRvalid), .gigLinkUp(gigLinkUp), .fastLinkUp(fastLinkUp), .phyEvents(phyEvents),
      .rxSymbolErrorFrame(rxSymbolErrorFrame), .diagStart(diagStart), .diagAbort(diagAbort),
      .diagPair(diagPair), .diagDone(diagDone), .diagResult(diagResult),
      .autoCrossoverEn(autoCrossoverEn), .forcedStraightSelect(forcedStraightSelect),
      .forcedCrossedSelect(forcedCrossedSelect), .irq(irq));

   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp, input string msg);
      testsRun++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask : check

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", testsRun, miscompares);
      if (miscompares == 0 && testsRun > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : wrap_up

   // Ends just after the taking edge, so next-cycle effects are already visible
   task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk);
      regReq <= '0;
      #1;
   endtask : reg_write

   task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk);
      regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
      @(posedge clk);
      regReq <= '0;
      #1;
      check({15'h0000, regRvalid}, 16'h0001, "read answer");
      d = regRdata;
   endtask : reg_read

   task automatic expect_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp, input string msg);
      logic [DATA_W-1:0] v;
      reg_read(a, v);
      check(v, exp, msg);
   endtask : expect_reg

   task automatic pass_cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : pass_cycles

   task automatic pulse_events(input pdi_phy_event_s ev, input logic symErr);
      @(posedge clk);
      phyEvents <= ev;
      rxSymbolErrorFrame <= symErr;
      @(posedge clk);
      phyEvents <= '0;
      rxSymbolErrorFrame <= 1'b0;
   endtask : pulse_events

   task automatic set_link(input logic gig, input logic fast);
      @(posedge clk);
      gigLinkUp <= gig;
      fastLinkUp <= fast;
      pass_cycles(3);
   endtask : set_link

   task automatic engine_done(input logic [1:0] code);
      @(posedge clk);
      diagDone <= 1'b1;
      diagResult <= code;
      @(posedge clk);
      diagDone <= 1'b0;
      diagResult <= ~code;
      pass_cycles(2);
   endtask : engine_done

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      wrap_up();
   end

   initial begin
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      pass_cycles(1);
      check({13'h0000, autoCrossoverEn, forcedStraightSelect, forcedCrossedSelect}, 16'h0004, "xovr reset");
      expect_reg(OFS_CABLE_DIAG, 16'h0000, "diag reset");
      expect_reg(OFS_LINK_STATE, 16'h0000, "link reset");
      expect_reg(OFS_RX_SYMBOL_ERROR, 16'h0000, "count reset");
      expect_reg(OFS_EVENT, 16'h0000, "event reset");
      expect_reg(OFS_CROSSOVER, 16'h0000, "xovr reg reset");
      expect_reg(12'h0128, 16'h0000, "unmapped read");
      // Each pair with one engine code (pair p gets code p); the reserved code must never be shown
      prevRes = DIAG_NO_FAULT;
      for (int p = 0; p < 4; p++) begin
         reg_write(OFS_CABLE_DIAG, 16'h8000 | 16'(p << 12));
         check({14'h0000, diagStart, diagAbort}, 16'h0002, "start pulse");
         check({14'h0000, diagPair}, 16'(p), "pair to engine");
         expect_reg(OFS_CABLE_DIAG, 16'h8000 | 16'(p << 12) | (prevRes << 8), "busy");
         engine_done(2'(p));
         prevRes = (p == 3) ? DIAG_NO_FAULT : 2'(p);
         expect_reg(OFS_CABLE_DIAG, 16'(p << 12) | (prevRes << 8), "result");
      end
      reg_write(OFS_CABLE_DIAG, 16'hB000);
      reg_write(OFS_CABLE_DIAG, 16'h3000);
      check({14'h0000, diagStart, diagAbort}, 16'h0001, "abort pulse");
      expect_reg(OFS_CABLE_DIAG, 16'h3000 | (prevRes << 8), "aborted keeps result");
      engine_done(DIAG_OPEN);
      expect_reg(OFS_CABLE_DIAG, 16'h3000 | (prevRes << 8), "idle done ignored");
      // Link events with all enables on
      reg_write(OFS_EVENT, 16'hFF00);
      expect_reg(OFS_EVENT, 16'hFF00, "enables");
      reg_write(OFS_LINK_STATE, 16'hFFFF);
      set_link(1'b1, 1'b0);
      check({15'h0000, irq}, 16'h0001, "irq on link up");
      expect_reg(OFS_EVENT, 16'hFF01, "link up flag");
      expect_reg(OFS_LINK_STATE, 16'h0002, "gig link");
      check({15'h0000, irq}, 16'h0000, "irq cleared");
      set_link(1'b1, 1'b1);
      expect_reg(OFS_LINK_STATE, 16'h0003, "both links");
      expect_reg(OFS_EVENT, 16'hFF00, "no flag while a link stays up");
      set_link(1'b0, 1'b1);
      expect_reg(OFS_LINK_STATE, 16'h0001, "fast link");
      expect_reg(OFS_EVENT, 16'hFF00, "no flag while a link stays up");
      set_link(1'b0, 1'b0);
      expect_reg(OFS_EVENT, 16'hFF04, "link down flag");
      // Each remaining event sets its own flag, which stays until read
      for (int i = 0; i < 6; i++) begin
         pulse_events(6'h20 >> i, 1'b0);
         pass_cycles(4);
         check({15'h0000, irq}, 16'h0001, "irq on event");
         expect_reg(OFS_EVENT, 16'hFF00 | 16'(1 << flagBit[i]), "event flag");
         expect_reg(OFS_EVENT, 16'hFF00, "flag cleared by read");
      end
      reg_write(OFS_EVENT, 16'h7F00);
      pulse_events(6'h20, 1'b0);
      pass_cycles(2);
      check({15'h0000, irq}, 16'h0000, "masked event");
      expect_reg(OFS_EVENT, 16'h7F80, "masked flag still set");
      // Symbol error frame counter
      reg_write(OFS_RX_SYMBOL_ERROR, 16'h1234);
      repeat (3) pulse_events('0, 1'b1);
      expect_reg(OFS_RX_SYMBOL_ERROR, 16'h0003, "count");
      expect_reg(OFS_RX_SYMBOL_ERROR, 16'h0000, "count cleared");
      // An error frame in the clearing read cycle survives the clear
      pulse_events('0, 1'b1);
      @(posedge clk);
      regReq <= '{wr: 1'b0, rd: 1'b1, addr: OFS_RX_SYMBOL_ERROR, wdata: 16'h0000};
      rxSymbolErrorFrame <= 1'b1;
      @(posedge clk);
      regReq <= '0;
      rxSymbolErrorFrame <= 1'b0;
      #1;
      check(regRdata, 16'h0001, "count before clear");
      expect_reg(OFS_RX_SYMBOL_ERROR, 16'h0001, "set wins over clear");
      // Crossover override and forced mode
      reg_write(OFS_CROSSOVER, 16'h0040);
      check({13'h0000, autoCrossoverEn, forcedStraightSelect, forcedCrossedSelect}, 16'h0001, "forced x");
      reg_write(OFS_CROSSOVER, 16'h00C0);
      check({13'h0000, autoCrossoverEn, forcedStraightSelect, forcedCrossedSelect}, 16'h0002, "forced s");
      reg_write(OFS_CROSSOVER, 16'hFFBF);
      check({13'h0000, autoCrossoverEn, forcedStraightSelect, forcedCrossedSelect}, 16'h0004, "auto");
      expect_reg(OFS_CROSSOVER, 16'hFFBF, "xovr readback");
      wrap_up();
   end
endmodule : phy_port_diag_irq_regs_tb
